// file: common/tod_defs.svh
`ifndef TOD_DEFS_SVH
`define TOD_DEFS_SVH
`define TOD_OFS_CTRL    12'h000
`define TOD_OFS_STAT    12'h004
`define TOD_OFS_MATCH   12'h008
`define TOD_OFS_COUNT   12'h00c
`define TOD_CTRL_EN     7
`define TOD_CTRL_SRC_HI 6
`define TOD_CTRL_SRC_LO 5
`define TOD_CTRL_RST    4
`define TOD_CTRL_CKEN   3
`define TOD_CTRL_PS_HI  2
`define TOD_CTRL_PS_LO  0
`define TOD_STAT_QF     7
`define TOD_STAT_SF     6
`define TOD_STAT_MF     5
`define TOD_STAT_QIE    4
`define TOD_STAT_SIE    3
`define TOD_STAT_MIE    2
`define TOD_STAT_MEN    1
`define TOD_STAT_WP     0
`define TOD_RST_SRC     2'h0
`define TOD_RST_PS      3'h1
`define TOD_RST_CNT     8'h00
`define TOD_RST_MATCH   6'h00
`define TOD_DIV_PS0     22'h0000fa
`define TOD_DIV_PS1     22'h002000
`define TOD_DIV_PS2     22'h001f40
`define TOD_DIV_PS3     22'h002580
`define TOD_DIV_PS4     22'h12c000
`define TOD_DIV_PS5     22'h0f4240
`define TOD_DIV_PS6     22'h1e8480
`define TOD_DIV_PS7     22'h3d0900
`endif

// file: common/todi_pkg.sv
`default_nettype none
package todi_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } todi_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } todi_apb_rsp_t;
   typedef enum logic [1:0] {
      TODI_SRC_EXT = 2'h0,
      TODI_SRC_LPO = 2'h1,
      TODI_SRC_IRC = 2'h2,
      TODI_SRC_OFF = 2'h3
   } todi_src_t;
endpackage
`default_nettype wire

// file: src/todi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tod_defs.svh"
module todi_top #(
   parameter int DIV_W = 22
) (
   input  wire logic                   core_clk,                   // 125 MHz clock
   input  wire logic                   rst_n,                      // Async reset
   input  wire todi_pkg::todi_apb_req_t apb_req,                   // APB request
   output var  todi_pkg::todi_apb_rsp_t apb_rsp,                   // APB response
   input  wire logic                   external_oscillator_clock,  // Source 00 pin
   input  wire logic                   low_power_1khz_oscillator,  // Source 01 pin
   input  wire logic                   internal_reference_clock,   // Source 10 pin
   output logic                        tod_irq                     // Shared request
);
   import todi_pkg::*;

   if (DIV_W < 22) begin : g_chk
      $error("DIV_W too narrow for the largest prescale divisor");
   end

   logic             module_enable_q;
   todi_src_t        timebase_source_select_q;
   logic             derived_clock_out_enable_q;
   logic [2:0]       timebase_prescale_select_q;
   logic             quarter_tick_flag_q;
   logic             whole_second_flag_q;
   logic             compare_hit_flag_q;
   logic             quarter_tick_irq_enable_q;
   logic             whole_second_irq_enable_q;
   logic             compare_hit_irq_enable_q;
   logic             compare_function_enable_q;
   logic             compare_write_pending_q;
   logic [5:0]       match_q;
   logic [1:0]       mqsec_q;
   logic [7:0]       quarter_second_counter_q;
   logic [7:0]       cnt_d;
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;

   // Source pins are asynchronous, so each passes three flops.
   logic [2:0] src_raw;
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] lvl_q;
   logic [2:0] src_edge;
   assign src_raw = {internal_reference_clock, low_power_1khz_oscillator,
                     external_oscillator_clock};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      assign src_edge[i] = (s2_q[i] == s3_q[i]) && s3_q[i] && !lvl_q[i];
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i]  <= 1'b0;
            s2_q[i]  <= 1'b0;
            s3_q[i]  <= 1'b0;
            lvl_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= src_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   // APB decode; registers answer with no wait state.
   logic wr_en;
   logic rd_setup;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_match;
   logic sel_count;
   logic mapped;
   logic [7:0] rd_byte;
   assign sel_ctrl  = apb_req.paddr == `TOD_OFS_CTRL;
   assign sel_stat  = apb_req.paddr == `TOD_OFS_STAT;
   assign sel_match = apb_req.paddr == `TOD_OFS_MATCH;
   assign sel_count = apb_req.paddr == `TOD_OFS_COUNT;
   assign mapped    = sel_ctrl || sel_stat || sel_match || sel_count;
   assign rd_setup  = apb_req.psel && !apb_req.penable;
   assign wr_en     = apb_req.psel && apb_req.penable && apb_req.pwrite
                      && apb_rsp.pready && mapped;

   logic [7:0] ctrl_rd;
   logic [7:0] stat_rd;
   assign ctrl_rd = {module_enable_q, timebase_source_select_q, 1'b0,
                     derived_clock_out_enable_q, timebase_prescale_select_q};
   assign stat_rd = {quarter_tick_flag_q, whole_second_flag_q, compare_hit_flag_q,
                     quarter_tick_irq_enable_q, whole_second_irq_enable_q,
                     compare_hit_irq_enable_q, compare_function_enable_q,
                     compare_write_pending_q};
   assign rd_byte = sel_ctrl  ? ctrl_rd :
                    sel_stat  ? stat_rd :
                    sel_match ? {match_q, mqsec_q} :
                    sel_count ? quarter_second_counter_q : 8'h00;

   logic wr_ctrl;
   logic wr_stat;
   logic wr_match;
   logic [7:0] wb;
   assign wb       = apb_req.pwdata[7:0];
   assign wr_ctrl  = wr_en && sel_ctrl;
   assign wr_stat  = wr_en && sel_stat;
   // A second match write while the first is still pending is dropped.
   assign wr_match = wr_en && sel_match && !compare_write_pending_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready  <= rd_setup;
         apb_rsp.pslverr <= rd_setup && !mapped;
         if (rd_setup) begin
            apb_rsp.prdata <= {24'h000000, rd_byte};
         end
      end
   end

   // Time base: pick a source, divide its edges down to 4 Hz.
   logic restart;
   logic src_tick;
   logic tick;
   logic [DIV_W-1:0] div_lim;
   logic [21:0] div_sel;
   assign restart = wr_ctrl && wb[`TOD_CTRL_RST];
   assign src_tick = (timebase_source_select_q == TODI_SRC_EXT) ? src_edge[0] :
                     (timebase_source_select_q == TODI_SRC_LPO) ? src_edge[1] :
                     (timebase_source_select_q == TODI_SRC_IRC) ? src_edge[2] :
                     1'b0;
   assign div_sel = (timebase_prescale_select_q == 3'h0) ? `TOD_DIV_PS0 :
                    (timebase_prescale_select_q == 3'h1) ? `TOD_DIV_PS1 :
                    (timebase_prescale_select_q == 3'h2) ? `TOD_DIV_PS2 :
                    (timebase_prescale_select_q == 3'h3) ? `TOD_DIV_PS3 :
                    (timebase_prescale_select_q == 3'h4) ? `TOD_DIV_PS4 :
                    (timebase_prescale_select_q == 3'h5) ? `TOD_DIV_PS5 :
                    (timebase_prescale_select_q == 3'h6) ? `TOD_DIV_PS6 :
                    `TOD_DIV_PS7;
   assign div_lim = DIV_W'(div_sel);
   assign tick = module_enable_q && !restart && src_tick
                 && (div_q == div_lim - DIV_W'(1));
   assign div_d = (!module_enable_q || restart || tick) ? '0 :
                  src_tick ? div_q + DIV_W'(1) : div_q;

   logic [7:0] cnt_inc;
   logic       hit;
   logic       sec_set;
   assign cnt_inc = quarter_second_counter_q + 8'h01;
   assign hit     = tick && compare_function_enable_q
                    && (cnt_inc == {match_q, mqsec_q});
   assign sec_set = tick && (cnt_inc[1:0] == 2'h0);
   // Disabling the module also returns the count to zero.
   assign cnt_d = (!module_enable_q || restart) ? `TOD_RST_CNT :
                  hit  ? {6'h00, cnt_inc[1:0]} :
                  tick ? cnt_inc : quarter_second_counter_q;

   // Next-state enables feed the request, so it follows a new enable without a cycle of lag.
   logic quarter_tick_irq_enable_d;
   logic whole_second_irq_enable_d;
   logic compare_hit_irq_enable_d;
   logic compare_function_enable_d;
   assign quarter_tick_irq_enable_d = wr_stat ? wb[`TOD_STAT_QIE] : quarter_tick_irq_enable_q;
   assign whole_second_irq_enable_d = wr_stat ? wb[`TOD_STAT_SIE] : whole_second_irq_enable_q;
   assign compare_hit_irq_enable_d  = wr_stat ? wb[`TOD_STAT_MIE] : compare_hit_irq_enable_q;
   assign compare_function_enable_d = wr_stat ? wb[`TOD_STAT_MEN] : compare_function_enable_q;

   // Set wins over a software clear in the same cycle.
   logic qf_d;
   logic sf_d;
   logic mf_d;
   logic irq_d;
   assign qf_d = (quarter_tick_flag_q && !(wr_stat && wb[`TOD_STAT_QF])) || tick;
   assign sf_d = (whole_second_flag_q && !(wr_stat && wb[`TOD_STAT_SF])) || sec_set;
   assign mf_d = (compare_hit_flag_q && !(wr_stat && wb[`TOD_STAT_MF])) || hit;
   assign irq_d = (qf_d && quarter_tick_irq_enable_d) || (sf_d && whole_second_irq_enable_d)
                  || (mf_d && compare_hit_irq_enable_d);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         quarter_second_counter_q <= `TOD_RST_CNT;
         div_q                    <= '0;
         quarter_tick_flag_q      <= 1'b0;
         whole_second_flag_q      <= 1'b0;
         compare_hit_flag_q       <= 1'b0;
         tod_irq                  <= 1'b0;
      end else begin
         quarter_second_counter_q <= cnt_d;
         div_q                    <= div_d;
         quarter_tick_flag_q      <= qf_d;
         whole_second_flag_q      <= sf_d;
         compare_hit_flag_q       <= mf_d;
         tod_irq                  <= irq_d;
      end
   end

   // Source and prescale are frozen while counting to keep the tick clean.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         module_enable_q            <= 1'b0;
         timebase_source_select_q   <= todi_src_t'(`TOD_RST_SRC);
         timebase_prescale_select_q <= `TOD_RST_PS;
         derived_clock_out_enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         module_enable_q            <= wb[`TOD_CTRL_EN];
         derived_clock_out_enable_q <= wb[`TOD_CTRL_CKEN];
         if (!module_enable_q) begin
            timebase_source_select_q   <= todi_src_t'(wb[`TOD_CTRL_SRC_HI:`TOD_CTRL_SRC_LO]);
            timebase_prescale_select_q <= wb[`TOD_CTRL_PS_HI:`TOD_CTRL_PS_LO];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         quarter_tick_irq_enable_q <= 1'b0;
         whole_second_irq_enable_q <= 1'b0;
         compare_hit_irq_enable_q  <= 1'b0;
         compare_function_enable_q <= 1'b0;
      end else begin
         quarter_tick_irq_enable_q <= quarter_tick_irq_enable_d;
         whole_second_irq_enable_q <= whole_second_irq_enable_d;
         compare_hit_irq_enable_q  <= compare_hit_irq_enable_d;
         compare_function_enable_q <= compare_function_enable_d;
      end
   end

   // The low match bits capture the live count phase at write time.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_q                 <= `TOD_RST_MATCH;
         mqsec_q                 <= 2'h0;
         compare_write_pending_q <= 1'b0;
      end else begin
         compare_write_pending_q <= wr_match;
         if (wr_match) begin
            match_q <= wb[7:2];
            mqsec_q <= quarter_second_counter_q[1:0];
         end
      end
   end

   logic seen_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_reset_values: assert property (!seen_q |-> ctrl_rd == 8'h01 && stat_rd == 8'h00
      && quarter_second_counter_q == 8'h00 && match_q == 6'h00)
      else $error("reset values wrong");
   chk_quarter_ungated: assert property (tick |=> quarter_tick_flag_q)
      else $error("quarter flag not set on tick");
   chk_second_wrap: assert property (tick && quarter_second_counter_q[1:0] == 2'h3
      |=> whole_second_flag_q && quarter_second_counter_q[1:0] == 2'h0)
      else $error("second flag missing at wrap");
   chk_flag_sticky: assert property (whole_second_flag_q && !(wr_stat && wb[`TOD_STAT_SF])
      |=> whole_second_flag_q)
      else $error("second flag lost without clear");
   chk_shared_irq: assert property (sec_set && quarter_tick_irq_enable_d
      && whole_second_irq_enable_d |=> tod_irq && quarter_tick_flag_q
      && whole_second_flag_q)
      else $error("shared request wrong");
   chk_match_gated: assert property (!compare_function_enable_q && !compare_hit_flag_q
      |=> !compare_hit_flag_q)
      else $error("match flag while disabled");
   chk_match_clear: assert property (hit |=> compare_hit_flag_q
      && quarter_second_counter_q[7:2] == 6'h00
      && quarter_second_counter_q[1:0] == $past(cnt_inc[1:0]))
      else $error("match did not clear upper bits");
   chk_irq_or: assert property (tod_irq == ((quarter_tick_flag_q && quarter_tick_irq_enable_q)
      || (whole_second_flag_q && whole_second_irq_enable_q)
      || (compare_hit_flag_q && compare_hit_irq_enable_q)))
      else $error("request not OR of flags");
   chk_counter_step: assert property (tick && !hit |=> quarter_second_counter_q
      == $past(quarter_second_counter_q) + 8'h01)
      else $error("counter step wrong");

   cov_match_irq: cover property (hit && compare_hit_irq_enable_q ##1 tod_irq);
   cov_second: cover property (sec_set ##1 whole_second_flag_q);
   cov_clear_race: cover property (tick && wr_stat && wb[`TOD_STAT_QF]);
   cov_slverr: cover property (apb_rsp.pslverr);
endmodule
`default_nettype wire

// file: sim/todi_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module todi_top_test;
   import todi_pkg::*;
   logic          core_clk;
   logic          rst_n;
   todi_apb_req_t req;
   todi_apb_rsp_t rsp;
   logic          tod_irq;
   logic          osc;
   logic [1:0]    osc_sel;
   logic [1:0]    ph;
   logic [31:0]   rd;
   logic          err;
   logic [7:0]    v;
   int            err_count;
   int            cmp_count;
   int            seed;

   todi_top dut_u (
      .core_clk                  (core_clk),
      .rst_n                     (rst_n),
      .apb_req                   (req),
      .apb_rsp                   (rsp),
      .external_oscillator_clock (osc & (osc_sel == 2'd0)),
      .low_power_1khz_oscillator (osc & (osc_sel == 2'd1)),
      .internal_reference_clock  (osc & (osc_sel == 2'd2)),
      .tod_irq                   (tod_irq)
   );

   always #4 core_clk = ~core_clk;

   // Source clock with three core cycles per phase, one more than the two the synchronizer needs.
   // Only the selected source toggles, so a wrong source choice never ticks.
   always @(posedge core_clk) begin
      if (ph == 2'd2) begin
         ph  <= 2'd0;
         osc <= ~osc;
      end else begin
         ph <= ph + 2'd1;
      end
   end

   function automatic logic [7:0] stat_x(input logic [2:0] f, input logic [3:0] en);
      return {f, en, 1'b0};
   endfunction

   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // The request is held until pready is seen at a rising edge; an idle cycle follows.
   // A slave that never answers is caught by the watchdog, not by a local limit.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
      @(posedge core_clk);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: {24'h000000, wd}};
      @(posedge core_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input string name);
      apb(1'b0, a, 8'h00);
      check(name, rd, {24'h000000, exp});
   endtask

   // Polls the counter; a tick is 1500 core cycles, so polling never skips a value.
   task automatic wait_cnt(input logic [7:0] n);
      int k;
      k = 0;
      do begin
         apb(1'b0, 12'h00c, 8'h00);
         k++;
      end while (rd[7:0] !== n && k < 6000);
      check("count", rd, {24'h000000, n});
   endtask

   task automatic irq_is(input logic exp);
      check("irq", {31'h0, tod_irq}, {31'h0, exp});
   endtask

   initial begin
      repeat (80000) @(posedge core_clk);
      err_count++;
      print_verdict();
   end

   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      req = '0;
      osc = 1'b0;
      ph = 2'd0;
      osc_sel = 2'd1;
      err_count = 0;
      cmp_count = 0;
      seed = 32'hd1682d34;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      rchk(12'h000, 8'h01, "ctrl");
      rchk(12'h004, 8'h00, "stat");
      rchk(12'h008, 8'h00, "match");
      rchk(12'h00c, 8'h00, "count");
      rchk(12'h010, 8'h00, "unmapped");
      check("slverr", {31'h0, err}, 32'h1);
      // While disabled the counter is held at zero, so the captured low bits read zero.
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         apb(1'b1, 12'h008, v);
         apb(1'b1, 12'h004, v);
         apb(1'b1, 12'h000, v & 8'h7f);
         rchk(12'h008, {v[7:2], 2'b00}, "match");
         rchk(12'h004, stat_x(3'h0, v[4:1]), "stat");
         rchk(12'h000, v & 8'h6f, "ctrl");
      end
      apb(1'b1, 12'h000, 8'h20);
      apb(1'b1, 12'h004, 8'hf0);
      apb(1'b1, 12'h000, 8'ha0);
      wait_cnt(8'h01);
      rchk(12'h004, stat_x(3'h4, 4'h8), "stat");
      irq_is(1'b1);
      wait_cnt(8'h02);
      irq_is(1'b1);
      apb(1'b1, 12'h004, 8'h88);
      repeat (2) @(posedge core_clk);
      irq_is(1'b0);
      wait_cnt(8'h03);
      rchk(12'h004, stat_x(3'h4, 4'h4), "stat");
      irq_is(1'b0);
      apb(1'b1, 12'h004, 8'h98);
      wait_cnt(8'h04);
      rchk(12'h004, stat_x(3'h6, 4'hc), "stat");
      irq_is(1'b1);
      apb(1'b1, 12'h004, 8'hd8);
      repeat (2) @(posedge core_clk);
      irq_is(1'b0);
      apb(1'b1, 12'h008, 8'h08);
      rchk(12'h008, 8'h08, "match");
      apb(1'b1, 12'h004, 8'he2);
      wait_cnt(8'h07);
      wait_cnt(8'h00);
      rchk(12'h004, stat_x(3'h7, 4'h1), "stat");
      irq_is(1'b0);
      apb(1'b1, 12'h004, 8'he6);
      wait_cnt(8'h07);
      wait_cnt(8'h00);
      rchk(12'h004, stat_x(3'h7, 4'h3), "stat");
      irq_is(1'b1);
      apb(1'b1, 12'h004, 8'he4);
      wait_cnt(8'h09);
      rchk(12'h004, stat_x(3'h6, 4'h2), "stat");
      irq_is(1'b0);
      apb(1'b1, 12'h000, 8'ha3);
      rchk(12'h000, 8'ha0, "ctrl");
      for (int s = 0; s < 3; s += 2) begin
         apb(1'b1, 12'h000, 8'h00);
         osc_sel <= 2'(s);
         apb(1'b1, 12'h000, {1'b0, 2'(s), 5'h00});
         apb(1'b1, 12'h000, {1'b1, 2'(s), 5'h00});
         wait_cnt(8'h01);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
